// *** dac_link_pkg.sv ***
// shared constants for the serial control link of the converter
package dac_link_pkg;
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int CODE_BITS = 16;
    localparam logic [4:0] FRAME_COUNT = 5'h18;
    localparam logic [4:0] COUNT_OVER = 5'h19;
    localparam logic [7:0] ADDR_NOP = 8'h00;
    localparam logic [7:0] ADDR_CODE = 8'h01;
    localparam logic [7:0] ADDR_READ = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h55;
    localparam logic [1:0] SEL_STATUS = 2'h0;
    localparam logic [1:0] SEL_CODE = 2'h1;
    localparam logic [1:0] SEL_CONFIG = 2'h2;
    localparam logic [15:0] CODE_MASK = 16'hffff << (DATA_BITS - CODE_BITS);
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam int BIT_CLEAR_SELECT = 15;
    localparam int BIT_OVERRANGE = 14;
    localparam int BIT_EXT_RESISTOR = 13;
    localparam int BIT_OUTPUT_ENABLE = 12;
    localparam int SLEW_RATE_HI = 11;
    localparam int SLEW_RATE_LO = 8;
    localparam int SLEW_STEP_HI = 7;
    localparam int SLEW_STEP_LO = 5;
    localparam int BIT_SLEW_ENABLE = 4;
    localparam int BIT_CHAIN_ENABLE = 3;
    localparam int RANGE_HI = 2;
    localparam int RANGE_LO = 0;
    localparam logic [2:0] RANGE_CUR_4_20 = 3'h5;
    localparam logic [2:0] RANGE_CUR_0_20 = 3'h6;
    localparam logic [2:0] RANGE_CUR_0_24 = 3'h7;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS = 200;
    localparam logic [3:0] HALF_CYCLES =
        4'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] REG_TX = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RX = 4'hc;
    localparam int CTRL_START = 0;
    localparam int CTRL_HOLD = 1;
endpackage

// *** dac_link_if.sv ***
// serial link wires between host controller and converter port
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
    logic sclk;
    logic latch;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    modport device (input sclk, input latch, input serial_in, output serial_out, output serial_out_oe);
    modport host (output sclk, output latch, output serial_in, input serial_out, input serial_out_oe);
endinterface
`default_nettype wire

// *** dac_serial_control_port.sv ***
// converter end of the serial control link
//
// Behaviour
// - rising clock shifts input in, msb first
// - shift always; load rise commits last 24 bits
// - free clock: host loads after exact bits
// - burst clock: exact cycles, then load
// - frame starts at edge shifting msb
// - frame invalid unless exactly 24 edges, or at least 24 while chaining
// - chaining only while chain_enable set
// - chained bits leave on falling edge
// - host sends 24 times N, loads once
// - read command then nop shifts register out
// - two low bits select readback register
// - output drive on at read load, off next; stays on while chain_enable set
// - all registers zero at power up
// - address 0x01 writes output code
// - address 0x55 writes configuration
// - enable bit gates outputs, range picks one; range 4 drives neither
// - overrange bit widens voltage range
// - selects external current set resistor
// - slew enable, rate and step fields
// - low three bits range, top clear select
// - range code maps to output kind
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_control_port (
    input wire logic clock_in,
    input wire logic reset_in,
    dac_link_if.device link,
    output logic [15:0] output_code_out,
    output logic [15:0] config_out,
    output logic output_enable_bit_out,
    output logic overrange_bit_out,
    output logic ext_resistor_select_out,
    output logic slew_enable_out,
    output logic [3:0] slew_update_rate_out,
    output logic [2:0] slew_step_size_out,
    output logic chain_enable_out,
    output logic clear_value_select_out,
    output logic [2:0] range_select_out,
    output logic voltage_active_out,
    output logic current_active_out,
    output logic frame_error_out,
    output logic commit_out
);
    typedef struct packed {
        logic sclk_meta;
        logic sclk_sync;
        logic sclk_prev;
        logic latch_meta;
        logic latch_sync;
        logic latch_prev;
        logic serial_in_meta;
        logic serial_in_sync;
        logic [23:0] shift;
        logic [4:0] edge_count;
        logic [15:0] output_code;
        logic [15:0] config_word;
        logic serial_out;
        logic serial_out_oe;
        logic voltage_active;
        logic current_active;
        logic frame_error;
        logic commit;
    } port_state_s;

    port_state_s state_reg;
    port_state_s state_next;
    logic sclk_rise;
    logic sclk_fall;
    logic latch_rise;
    logic frame_ok;
    logic chain_on;
    logic [7:0] frame_addr;
    logic [15:0] frame_data;
    logic [15:0] config_new;
    logic [15:0] readback;
    logic [2:0] range_new;

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synchronised pins
    assign sclk_rise = state_reg.sclk_sync & ~state_reg.sclk_prev;
    assign sclk_fall = ~state_reg.sclk_sync & state_reg.sclk_prev;
    assign latch_rise = state_reg.latch_sync & ~state_reg.latch_prev;
    assign chain_on = state_reg.config_word[dac_link_pkg::BIT_CHAIN_ENABLE];
    assign frame_addr = state_reg.shift[23:16];
    assign frame_data = state_reg.shift[15:0];

    always_comb begin
        // standalone needs exactly 24 edges, chaining keeps the last 24
        if (chain_on) begin
            frame_ok = state_reg.edge_count >= dac_link_pkg::FRAME_COUNT;
        end else begin
            frame_ok = state_reg.edge_count == dac_link_pkg::FRAME_COUNT;
        end
    end

    always_comb begin
        unique case (frame_data[1:0])
            dac_link_pkg::SEL_STATUS: readback = 16'h0000;
            dac_link_pkg::SEL_CODE: readback = state_reg.output_code;
            dac_link_pkg::SEL_CONFIG: readback = state_reg.config_word;
            default: readback = 16'h0000;
        endcase
    end

    always_comb begin
        config_new = state_reg.config_word;
        if (latch_rise && frame_ok && frame_addr == dac_link_pkg::ADDR_CONFIG) begin
            config_new = frame_data;
        end
    end
    assign range_new = config_new[dac_link_pkg::RANGE_HI:dac_link_pkg::RANGE_LO];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.sclk_meta = link.sclk;
        state_next.sclk_sync = state_reg.sclk_meta;
        state_next.sclk_prev = state_reg.sclk_sync;
        state_next.latch_meta = link.latch;
        state_next.latch_sync = state_reg.latch_meta;
        state_next.latch_prev = state_reg.latch_sync;
        state_next.serial_in_meta = link.serial_in;
        state_next.serial_in_sync = state_reg.serial_in_meta;
        state_next.commit = 1'b0;
        if (sclk_rise) begin
            // shifting ignores the load level
            state_next.shift = {state_reg.shift[22:0], state_reg.serial_in_sync};
            if (state_reg.edge_count != dac_link_pkg::COUNT_OVER) begin
                state_next.edge_count = state_reg.edge_count + 5'h01;
            end
        end
        if (sclk_fall && state_reg.serial_out_oe) begin
            state_next.serial_out = state_reg.shift[23];
        end
        if (latch_rise) begin
            state_next.edge_count = 5'h00;
            state_next.frame_error = ~frame_ok;
            if (frame_ok) begin
                unique case (frame_addr)
                    dac_link_pkg::ADDR_NOP: begin
                        state_next.commit = 1'b1;
                        state_next.serial_out_oe = chain_on;
                    end
                    dac_link_pkg::ADDR_CODE: begin
                        state_next.commit = 1'b1;
                        state_next.output_code = frame_data & dac_link_pkg::CODE_MASK;
                        state_next.serial_out_oe = chain_on;
                    end
                    dac_link_pkg::ADDR_CONFIG: begin
                        state_next.commit = 1'b1;
                        state_next.config_word = frame_data;
                        state_next.serial_out_oe = frame_data[dac_link_pkg::BIT_CHAIN_ENABLE];
                    end
                    dac_link_pkg::ADDR_READ: begin
                        state_next.commit = 1'b1;
                        // selected value waits in the shift register for the nop frame
                        state_next.shift = {dac_link_pkg::ADDR_NOP, readback};
                        state_next.serial_out = dac_link_pkg::ADDR_NOP[7];
                        state_next.serial_out_oe = 1'b1;
                    end
                    default: begin
                        state_next.commit = 1'b0;
                    end
                endcase
            end
        end
        // enable gates both outputs, range 0-3 picks voltage, 5-7 current, 4 neither
        state_next.voltage_active = config_new[dac_link_pkg::BIT_OUTPUT_ENABLE]
            & ~range_new[dac_link_pkg::RANGE_HI];
        state_next.current_active = config_new[dac_link_pkg::BIT_OUTPUT_ENABLE]
            & (range_new == dac_link_pkg::RANGE_CUR_4_20
            || range_new == dac_link_pkg::RANGE_CUR_0_20
            || range_new == dac_link_pkg::RANGE_CUR_0_24);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign link.serial_out = state_reg.serial_out;
    assign link.serial_out_oe = state_reg.serial_out_oe;
    assign output_code_out = state_reg.output_code;
    assign config_out = state_reg.config_word;
    assign output_enable_bit_out = state_reg.config_word[dac_link_pkg::BIT_OUTPUT_ENABLE];
    assign overrange_bit_out = state_reg.config_word[dac_link_pkg::BIT_OVERRANGE];
    assign ext_resistor_select_out =
        state_reg.config_word[dac_link_pkg::BIT_EXT_RESISTOR];
    assign slew_enable_out = state_reg.config_word[dac_link_pkg::BIT_SLEW_ENABLE];
    assign slew_update_rate_out =
        state_reg.config_word[dac_link_pkg::SLEW_RATE_HI:dac_link_pkg::SLEW_RATE_LO];
    assign slew_step_size_out =
        state_reg.config_word[dac_link_pkg::SLEW_STEP_HI:dac_link_pkg::SLEW_STEP_LO];
    assign chain_enable_out = chain_on;
    assign clear_value_select_out =
        state_reg.config_word[dac_link_pkg::BIT_CLEAR_SELECT];
    assign range_select_out =
        state_reg.config_word[dac_link_pkg::RANGE_HI:dac_link_pkg::RANGE_LO];
    assign voltage_active_out = state_reg.voltage_active;
    assign current_active_out = state_reg.current_active;
    assign frame_error_out = state_reg.frame_error;
    assign commit_out = state_reg.commit;
endmodule
`default_nettype wire

// *** dac_link_host.sv ***
// host end of the serial link with an avalon-mm command port
`timescale 1ns/1ps
`default_nettype none
module dac_link_host (
    input wire logic clock_in,
    input wire logic reset_in,
    dac_link_if.host link,
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_LOW = 4'h2,
        H_HIGH = 4'h4,
        H_LATCH = 4'h8
    } host_phase_e;

    typedef struct packed {
        host_phase_e phase;
        logic [3:0] div;
        logic [4:0] bits;
        logic [23:0] tx;
        logic [23:0] rx;
        logic [23:0] tx_word;
        logic hold;
        logic sclk;
        logic latch;
        logic serial_in;
        logic sdo_meta;
        logic sdo_sync;
        logic waitrequest;
        logic [31:0] readdata;
    } host_state_s;

    host_state_s state_reg;
    host_state_s state_next;
    logic busy;
    logic start_req;
    logic half_done;

    assign busy = state_reg.phase != H_IDLE;
    assign half_done = state_reg.div == dac_link_pkg::HALF_CYCLES - 4'h1;
    // a start while a frame runs is stalled by waitrequest
    assign start_req = write_in && address_in == dac_link_pkg::REG_CTRL
        && writedata_in[dac_link_pkg::CTRL_START];

    always_comb begin
        state_next = state_reg;
        state_next.sdo_meta = link.serial_out;
        state_next.sdo_sync = state_reg.sdo_meta;
        state_next.div = half_done ? 4'h0 : state_reg.div + 4'h1;
        state_next.waitrequest = 1'b1;
        if ((read_in || write_in) && state_reg.waitrequest && !(start_req && busy)) begin
            state_next.waitrequest = 1'b0;
        end
        if (read_in && state_reg.waitrequest) begin
            unique case (address_in)
                dac_link_pkg::REG_TX: state_next.readdata = {8'h00, state_reg.tx_word};
                dac_link_pkg::REG_CTRL: state_next.readdata = {30'h0, state_reg.hold, 1'b0};
                dac_link_pkg::REG_STATUS: state_next.readdata = {31'h0, busy};
                dac_link_pkg::REG_RX: state_next.readdata = {8'h00, state_reg.rx};
                default: state_next.readdata = 32'h0000_0000;
            endcase
        end
        unique case (state_reg.phase)
            H_IDLE: begin
                state_next.div = 4'h0;
            end
            H_LOW: begin
                if (half_done) begin
                    state_next.sclk = 1'b1;
                    state_next.rx = {state_reg.rx[22:0], state_reg.sdo_sync};
                    state_next.bits = state_reg.bits + 5'h01;
                    state_next.phase = H_HIGH;
                end
            end
            H_HIGH: begin
                if (half_done) begin
                    state_next.sclk = 1'b0;
                    state_next.tx = {state_reg.tx[22:0], 1'b0};
                    state_next.serial_in = state_reg.tx[22];
                    if (state_reg.bits == dac_link_pkg::FRAME_COUNT) begin
                        // exact burst, load only after final cycle
                        state_next.phase = state_reg.hold ? H_IDLE : H_LATCH;
                        state_next.latch = ~state_reg.hold;
                    end else begin
                        state_next.phase = H_LOW;
                    end
                end
            end
            H_LATCH: begin
                if (half_done) begin
                    state_next.latch = 1'b0;
                    state_next.phase = H_IDLE;
                end
            end
            default: begin
                state_next.phase = H_IDLE;
            end
        endcase
        if (write_in && !state_reg.waitrequest) begin
            if (address_in == dac_link_pkg::REG_TX) begin
                state_next.tx_word = writedata_in[23:0];
            end
            if (address_in == dac_link_pkg::REG_CTRL) begin
                state_next.hold = writedata_in[dac_link_pkg::CTRL_HOLD];
                if (writedata_in[dac_link_pkg::CTRL_START]) begin
                    state_next.phase = H_LOW;
                    state_next.div = 4'h0;
                    state_next.bits = 5'h00;
                    state_next.sclk = 1'b0;
                    state_next.tx = state_reg.tx_word;
                    state_next.serial_in = state_reg.tx_word[23];
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '{phase: H_IDLE, waitrequest: 1'b1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.sclk = state_reg.sclk;
    assign link.latch = state_reg.latch;
    assign link.serial_in = state_reg.serial_in;
    assign readdata_out = state_reg.readdata;
    assign waitrequest_out = state_reg.waitrequest;
endmodule
`default_nettype wire

// *** dac_link_checker.sv ***
// assertions on the serial link wires between host and converter
`timescale 1ns/1ps
`default_nettype none
module dac_link_checker (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic sclk,
    input wire logic latch,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic [7:0] rise_count;
    logic sclk_q;
    logic latch_q;
    logic count_whole;
    assign count_whole = rise_count != 8'h00 && rise_count % dac_link_pkg::FRAME_BITS == 0;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////////////
    // clock rises since the last load strobe
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rise_count <= 8'h00;
            sclk_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            latch_q <= latch;
            if (latch && !latch_q) begin
                rise_count <= 8'h00;
            end else if (sclk && !sclk_q) begin
                rise_count <= rise_count + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence latch_pulse;
        latch [*8] ##1 !latch;
    endsequence
    sequence clk_high_half;
        sclk [*8] ##1 !sclk;
    endsequence
    a_latch_width: assert property ($rose(latch) |-> latch_pulse)
        else $error("load strobe width wrong");
    a_sclk_half: assert property ($rose(sclk) |-> clk_high_half)
        else $error("serial clock high phase wrong");
    a_serial_in_steady: assert property ($rose(sclk) |-> $stable(serial_in) [*8])
        else $error("serial data moved while clock high");
    a_clock_still: assert property (latch |-> !sclk)
        else $error("serial clock active during load");
    a_frame_count: assert property ($rose(latch) |-> count_whole)
        else $error("load after wrong clock count");
    a_oe_at_load: assert property ($changed(serial_out_oe) |-> latch)
        else $error("output drive changed outside load");
    a_out_on_fall: assert property ($changed(serial_out) && !latch |-> !sclk)
        else $error("serial output changed while clock high");
    a_reset_quiet: assert property ($fell(reset_in) |-> !serial_out_oe && !sclk && !latch)
        else $error("link not idle after reset");
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for both ends of the converter serial link
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, got, exp_w, w, w2;
    logic wait_req, commit, ferr, ferr_b;
    logic [15:0] code, cfg, code_b, m_code, m_cfg;
    wire [17:0] flds;
    logic [31:0] notes[$];
    integer seed = 64;
    int num_errors = 0;
    int compares = 0;
    dac_link_if link();
    dac_link_if link_b();
    dac_link_host dac_link_host_inst(.clock_in(clock_in), .reset_in(reset_in), .link(link),
        .address_in(address), .read_in(read), .write_in(write), .writedata_in(wdata),
        .readdata_out(rdata), .waitrequest_out(wait_req));
    dac_serial_control_port dac_serial_control_port_inst(.clock_in(clock_in),
        .reset_in(reset_in), .link(link), .output_code_out(code), .config_out(cfg),
        .output_enable_bit_out(flds[17]), .overrange_bit_out(flds[16]),
        .ext_resistor_select_out(flds[15]), .slew_enable_out(flds[14]),
        .slew_update_rate_out(flds[13:10]), .slew_step_size_out(flds[9:7]),
        .chain_enable_out(flds[6]), .clear_value_select_out(flds[5]),
        .range_select_out(flds[4:2]), .voltage_active_out(flds[1]),
        .current_active_out(flds[0]), .frame_error_out(ferr), .commit_out(commit));
    dac_serial_control_port dac_serial_control_port_inst_b(.clock_in(clock_in),
        .reset_in(reset_in), .link(link_b), .output_code_out(code_b), .config_out(),
        .output_enable_bit_out(), .overrange_bit_out(), .ext_resistor_select_out(),
        .slew_enable_out(), .slew_update_rate_out(), .slew_step_size_out(),
        .chain_enable_out(), .clear_value_select_out(), .range_select_out(),
        .voltage_active_out(), .current_active_out(), .frame_error_out(ferr_b),
        .commit_out());
    dac_link_checker dac_link_checker_inst(.clock_in(clock_in), .reset_in(reset_in),
        .sclk(link.sclk), .latch(link.latch), .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe(link.serial_out_oe));
    always #12.5 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] fexp(input logic [15:0] c);
        return {c[12], c[14], c[13], c[4], c[11:8], c[7:5], c[3], c[15], c[2:0],
            c[12] & ~c[2], c[12] & (c[2:0] > 3'h4)};
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        address <= a;
        read <= rd;
        write <= ~rd;
        wdata <= d;
        do begin
            @(posedge clock_in);
            n++;
        end while (wait_req !== 1'b0 && n < 2000);
        got = rdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 2000) chk("bus wait", 32'h0, 32'h1);
    endtask
    // one frame through the host; the model follows the committed word
    task automatic frame(input logic [23:0] f, input logic hold);
        int n;
        n = 0;
        if (!hold && f[23:16] == 8'h01) m_code = f[15:0] & dac_link_pkg::CODE_MASK;
        if (!hold && f[23:16] == 8'h55) m_cfg = f[15:0];
        if (!hold && f[23:16] inside {8'h00, 8'h01, 8'h02, 8'h55}) begin
            notes.push_back({m_code, m_cfg});
        end
        bus(1'b0, dac_link_pkg::REG_TX, {8'h00, f});
        bus(1'b0, dac_link_pkg::REG_CTRL, {30'h0, hold, 1'b1});
        do begin
            bus(1'b1, dac_link_pkg::REG_STATUS, 32'h0);
            n++;
        end while (got[0] !== 1'b0 && n < 500);
        if (n >= 500) chk("frame busy", 32'h0, 32'h1);
    endtask
    // bench-driven frame with a chosen count of clock rises
    task automatic raw(input int n, input logic [23:0] f);
        for (int i = 0; i < n; i++) begin
            link_b.serial_in <= f[23 - (i % 24)];
            repeat (4) @(posedge clock_in);
            link_b.sclk <= 1'b1;
            repeat (4) @(posedge clock_in);
            link_b.sclk <= 1'b0;
        end
        repeat (4) @(posedge clock_in);
        link_b.latch <= 1'b1;
        repeat (8) @(posedge clock_in);
        link_b.latch <= 1'b0;
        repeat (8) @(posedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock_in) begin
        if (commit === 1'b1) begin
            if (notes.size() == 0) begin
                chk("stray commit", 32'h0, 32'h1);
            end else begin
                exp_w = notes.pop_front();
                chk("output_code", exp_w[31:16], code);
                chk("configuration", exp_w[15:0], cfg);
                chk("fields", fexp(exp_w[15:0]), flds);
                chk("frame error", 32'h0, ferr);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clock_in);
        num_errors++;
        close_out();
    end
    initial begin
        link_b.sclk = 1'b0;
        link_b.latch = 1'b0;
        link_b.serial_in = 1'b0;
        m_code = 16'h0;
        m_cfg = 16'h0;
        repeat (10) @(posedge clock_in);
        reset_in <= 1'b0;
        @(negedge clock_in);
        chk("reset registers", 32'h0, {code, cfg});
        chk("reset drive", 32'h0, link.serial_out_oe);
        $display("test reset done");
        w = $random(seed);
        frame({8'h01, w[15:0]}, 1'b0);
        bus(1'b1, dac_link_pkg::REG_TX, 32'h0);
        chk("host tx word", {16'h0001, w[15:0]}, got);
        repeat (3) begin
            w = $random(seed);
            frame({8'h55, w[15:0] & 16'hfff7}, 1'b0);
        end
        for (int r = 0; r < 8; r++) frame({8'h55, 16'h1000 | 16'(r)}, 1'b0);
        frame({8'h33, w[15:0]}, 1'b0);
        chk("drive after unknown", 32'h0, link.serial_out_oe);
        $display("test writes done");
        for (int s = 0; s < 4; s++) begin
            w = $random(seed);
            frame({8'h02, w[15:2], 2'(s)}, 1'b0);
            chk("drive at read", 32'h1, link.serial_out_oe);
            frame(24'h000000, 1'b0);
            chk("drive after nop", 32'h0, link.serial_out_oe);
            bus(1'b1, dac_link_pkg::REG_RX, 32'h0);
            exp_w = {16'h0, s == 1 ? m_code : s == 2 ? m_cfg : 16'h0};
            chk("readback", exp_w, {8'h00, got[23:0]});
        end
        $display("test readback done");
        frame({8'h55, 16'h0008}, 1'b0);
        chk("chain drive", 32'h1, link.serial_out_oe);
        w = $random(seed);
        w2 = $random(seed);
        frame({8'h01, w[15:0]}, 1'b1);
        bus(1'b1, dac_link_pkg::REG_CTRL, 32'h0);
        chk("host hold bit", 32'h2, got);
        frame({8'h01, w2[15:0]}, 1'b0);
        bus(1'b1, dac_link_pkg::REG_RX, 32'h0);
        chk("chained out", {8'h01, w[15:0]}, got[23:0]);
        frame({8'h55, 16'h0000}, 1'b0);
        chk("chain off drive", 32'h0, link.serial_out_oe);
        $display("test chain done");
        raw(23, 24'h011234);
        chk("short frame", {16'h1, 16'h0}, {15'h0, ferr_b, code_b});
        raw(25, 24'h011234);
        chk("long frame", {16'h1, 16'h0}, {15'h0, ferr_b, code_b});
        raw(24, 24'h011234);
        chk("exact frame", {16'h0, 16'h1234}, {15'h0, ferr_b, code_b});
        $display("test frame count done");
        repeat (20) @(posedge clock_in);
        chk("notes left", 32'h0, notes.size());
        close_out();
    end
endmodule
`default_nettype wire
